/* File: logic/phypsr_regs.sv */
`timescale 1ns/100ps
`include "phypsr_consts.svh"

module phypsr_regs
   import phypsr_pkg::*;
(
   // Clock and reset
   input  wire logic              CORE_CLK,
   input  wire logic              RST,
   // Register access from link side
   input  wire phypsr_req_t       REG_REQ,
   output logic [7:0]             REG_RDATA,
   output logic                   REG_RVALID,
   // Core event inputs
   input  wire logic              ARB_TIMEOUT,
   input  wire logic              LOOP_FLAG,
   input  wire logic              PWR_FAIL_FLAG,
   input  wire logic              SUSPEND_FUNCTION_SELECT,
   input  wire logic              LINK_POWER_STATE_INPUT,
   // Per-port inputs
   input  wire phypsr_port_stat_t PORT_STAT [`PHYPSR_NUM_PORTS],
   input  wire logic [1:0]        PORT_RESUME,
   input  wire logic [1:0]        PORT_SUSPEND_ERR,
   // Controls to the core
   output logic                   ARB_ACCEL_EN,
   output logic                   MULTISPEED_EN,
   output logic [1:0]             PORT_OFF,
   output logic [2:0]             PAGE_SEL,
   output logic                   LINK_WAKE_OUTPUT
);

   logic       timeout_q;
   logic       port_event_q;
   logic       accel_q;
   logic       multi_q;
   logic       watchdog_q;
   logic [2:0] page_q;
   logic [3:0] port_q;
   logic [1:0] port_off_q;
   logic [1:0] irq_en_q;
   logic [1:0] fault_q;
   logic [1:0] port_change;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic       rvalid_q;
   logic       wr_events;
   logic       wr_select;
   logic       wr_pstat0;
   logic       wr_pstat1;
   logic       event_set;
   logic [4:0] wake_cnt_q;
   logic       wake_q;
   logic       wake_cond;

   // Port status page visible only for a valid port code
   function automatic logic port_page_hit(input logic [2:0] pg,
                                          input logic [3:0] ps);
      port_page_hit = (pg == `PHYPSR_PAGE_PORT_STATUS) &&
                      ((ps == `PHYPSR_PORT_0) || (ps == `PHYPSR_PORT_1));
   endfunction

   function automatic logic sel_port1(input logic [3:0] ps);
      sel_port1 = (ps == `PHYPSR_PORT_1);
   endfunction

   assign wr_events = REG_REQ.wr && (REG_REQ.addr == `PHYPSR_ADDR_EVENTS);
   assign wr_select = REG_REQ.wr && (REG_REQ.addr == `PHYPSR_ADDR_SELECT);
   assign wr_pstat0 = REG_REQ.wr && (REG_REQ.addr == `PHYPSR_ADDR_PSTAT0)
                      && port_page_hit(page_q, port_q);
   assign wr_pstat1 = REG_REQ.wr && (REG_REQ.addr == `PHYPSR_ADDR_PSTAT1)
                      && port_page_hit(page_q, port_q);

   // Time-out flag: a set in the clearing cycle wins
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         timeout_q <= 1'b0;
      else if (ARB_TIMEOUT)
         timeout_q <= 1'b1;
      else if (wr_events && REG_REQ.wdata[`PHYPSR_BIT_TIMEOUT])
         timeout_q <= 1'b0;
   end

   // Plain control bits
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         accel_q    <= 1'b0;
         multi_q    <= 1'b0;
         watchdog_q <= 1'b0;
      end
      else if (wr_events)
      begin
         // Changing this with a request pending is the link's hazard
         accel_q    <= REG_REQ.wdata[`PHYPSR_BIT_ACCEL];
         multi_q    <= REG_REQ.wdata[`PHYPSR_BIT_MULTI];
         watchdog_q <= REG_REQ.wdata[`PHYPSR_BIT_WATCHDOG];
      end
   end

   // Page and port selectors
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         page_q <= `PHYPSR_RST_PAGE;
         port_q <= `PHYPSR_RST_PORT;
      end
      else if (wr_select)
      begin
         page_q <= REG_REQ.wdata[`PHYPSR_PAGE_MSB:`PHYPSR_PAGE_LSB];
         // Vendor page needs port 1; left to software
         port_q <= REG_REQ.wdata[`PHYPSR_PORT_MSB:`PHYPSR_PORT_LSB];
      end
   end

   // Per-port storage and change detection
   genvar gi;
   generate
      for (gi = 0; gi < `PHYPSR_NUM_PORTS; gi = gi + 1)
      begin : g_port
         logic       hit;
         logic [3:0] cur;
         logic [3:0] prev_q;

         assign hit = (sel_port1(port_q) == (gi == 1));
         assign cur = {PORT_STAT[gi].link_attached,
                       PORT_STAT[gi].bias_present,
                       port_off_q[gi], fault_q[gi]};

         always_ff @(posedge CORE_CLK or posedge RST)
         begin
            if (RST)
            begin
               port_off_q[gi] <= 1'b0;
               irq_en_q[gi]   <= 1'b0;
            end
            else
            begin
               if (wr_pstat0 && hit)
                  port_off_q[gi] <=
                     REG_REQ.wdata[`PHYPSR_BIT_PORT_OFF];
               if (wr_pstat1 && hit)
                  irq_en_q[gi] <= REG_REQ.wdata[`PHYPSR_BIT_IRQ_EN];
            end
         end

         always_ff @(posedge CORE_CLK or posedge RST)
         begin
            if (RST)
               fault_q[gi] <= 1'b0;
            else if (PORT_SUSPEND_ERR[gi] && SUSPEND_FUNCTION_SELECT)
               fault_q[gi] <= 1'b1;
            else if (wr_pstat1 && hit &&
                     REG_REQ.wdata[`PHYPSR_BIT_FAULT])
               fault_q[gi] <= 1'b0;
         end

         // Zero start is safe: the enable also resets low
         always_ff @(posedge CORE_CLK or posedge RST)
         begin
            if (RST)
               prev_q <= 4'h0;
            else
               prev_q <= cur;
         end

         assign port_change[gi] = irq_en_q[gi] &&
                                  (cur != prev_q);
      end
   endgenerate

   // Port event flag, gated off with suspend/resume disabled
   assign event_set = SUSPEND_FUNCTION_SELECT &&
                      ((|port_change) ||
                       (watchdog_q && (|PORT_RESUME)));

   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         port_event_q <= 1'b0;
      else if (event_set)
         port_event_q <= 1'b1;
      else if (wr_events && REG_REQ.wdata[`PHYPSR_BIT_PORT_EVENT])
         port_event_q <= 1'b0;
   end

   // Read path; unmapped addresses and other pages read zero
   always_comb
   begin
      rdata_d = `PHYPSR_RST_BYTE;
      unique case (REG_REQ.addr)
         `PHYPSR_ADDR_EVENTS:
         begin
            rdata_d[`PHYPSR_BIT_WATCHDOG]   = watchdog_q;
            rdata_d[`PHYPSR_BIT_LOOP]       = LOOP_FLAG;
            rdata_d[`PHYPSR_BIT_PWR_FAIL]   = PWR_FAIL_FLAG;
            rdata_d[`PHYPSR_BIT_TIMEOUT]    = timeout_q;
            rdata_d[`PHYPSR_BIT_PORT_EVENT] = port_event_q;
            rdata_d[`PHYPSR_BIT_ACCEL]      = accel_q;
            rdata_d[`PHYPSR_BIT_MULTI]      = multi_q;
         end
         `PHYPSR_ADDR_SELECT:
         begin
            rdata_d[`PHYPSR_PAGE_MSB:`PHYPSR_PAGE_LSB] = page_q;
            rdata_d[`PHYPSR_PORT_MSB:`PHYPSR_PORT_LSB] = port_q;
         end
         `PHYPSR_ADDR_PSTAT0:
         begin
            if (port_page_hit(page_q, port_q))
            begin
               rdata_d[`PHYPSR_PA_MSB:`PHYPSR_PA_LSB] =
                  PORT_STAT[sel_port1(port_q)].pair_a_line_state;
               rdata_d[`PHYPSR_PB_MSB:`PHYPSR_PB_LSB] =
                  PORT_STAT[sel_port1(port_q)].pair_b_line_state;
               rdata_d[`PHYPSR_BIT_ROLE] =
                  PORT_STAT[sel_port1(port_q)].downstream_role;
               rdata_d[`PHYPSR_BIT_ATTACHED] =
                  PORT_STAT[sel_port1(port_q)].link_attached;
               rdata_d[`PHYPSR_BIT_BIAS] =
                  PORT_STAT[sel_port1(port_q)].bias_present;
               rdata_d[`PHYPSR_BIT_PORT_OFF] =
                  port_off_q[sel_port1(port_q)];
            end
         end
         `PHYPSR_ADDR_PSTAT1:
         begin
            if (port_page_hit(page_q, port_q))
            begin
               rdata_d[`PHYPSR_RATE_MSB:`PHYPSR_RATE_LSB] =
                  PORT_STAT[sel_port1(port_q)].peer_top_rate;
               rdata_d[`PHYPSR_BIT_IRQ_EN] =
                  irq_en_q[sel_port1(port_q)];
               rdata_d[`PHYPSR_BIT_FAULT] =
                  fault_q[sel_port1(port_q)];
            end
         end
         default:
            rdata_d = `PHYPSR_RST_BYTE;
      endcase
   end

   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         rdata_q  <= `PHYPSR_RST_BYTE;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rvalid_q <= REG_REQ.rd;
         if (REG_REQ.rd)
            rdata_q <= rdata_d;
      end
   end

   // Wake clock; watchdog off hides loop/power/time-out while link is down
   assign wake_cond = !LINK_POWER_STATE_INPUT &&
                      (port_event_q ||
                       (watchdog_q &&
                        (LOOP_FLAG || PWR_FAIL_FLAG || timeout_q)));

   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         wake_cnt_q <= 5'h00;
         wake_q     <= 1'b0;
      end
      else if (!wake_cond)
      begin
         wake_cnt_q <= 5'h00;
         wake_q     <= 1'b0;
      end
      else if (wake_cnt_q == 5'(`PHYPSR_WAKE_HALF_CYC - 1))
      begin
         wake_cnt_q <= 5'h00;
         wake_q     <= !wake_q;
      end
      else
         wake_cnt_q <= wake_cnt_q + 5'h01;
   end

   assign REG_RDATA        = rdata_q;
   assign REG_RVALID       = rvalid_q;
   assign ARB_ACCEL_EN     = accel_q;
   assign MULTISPEED_EN    = multi_q;
   assign PORT_OFF         = port_off_q;
   assign PAGE_SEL         = page_q;
   assign LINK_WAKE_OUTPUT = wake_q;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   AST_TIMEOUT_SET: assert property (ARB_TIMEOUT |=> timeout_q)
      else $error("timeout flag not set");
   AST_TIMEOUT_HOLD: assert property (
      timeout_q && !(wr_events && REG_REQ.wdata[`PHYPSR_BIT_TIMEOUT])
      |=> timeout_q)
      else $error("timeout flag lost");
   AST_EVENT_GATED: assert property (
      !SUSPEND_FUNCTION_SELECT && !port_event_q |=> !port_event_q)
      else $error("port event set while function select low");
   AST_EVENT_CHANGE: assert property (
      SUSPEND_FUNCTION_SELECT && (|port_change) |=> port_event_q)
      else $error("port change did not set port event");
   AST_EVENT_RESUME: assert property (
      SUSPEND_FUNCTION_SELECT && watchdog_q && (|PORT_RESUME)
      |=> port_event_q)
      else $error("resume did not set port event");
   AST_EVENT_CLEAR: assert property (
      wr_events && REG_REQ.wdata[`PHYPSR_BIT_PORT_EVENT] && !event_set
      |=> !port_event_q)
      else $error("port event not cleared");
   AST_ACCEL_OUT: assert property (
      wr_events |=> ARB_ACCEL_EN == $past(REG_REQ.wdata[`PHYPSR_BIT_ACCEL]))
      else $error("acceleration enable not updated");
   AST_MULTI_OUT: assert property (
      wr_events |=> MULTISPEED_EN == $past(REG_REQ.wdata[`PHYPSR_BIT_MULTI]))
      else $error("multi-speed enable not updated");
   AST_PAGE_OUT: assert property (
      wr_select |=>
      PAGE_SEL == $past(REG_REQ.wdata[`PHYPSR_PAGE_MSB:`PHYPSR_PAGE_LSB]))
      else $error("page selector not updated");
   AST_PORT_OFF_HOLD: assert property (
      !wr_pstat0 |=> $stable(PORT_OFF))
      else $error("port disable changed without a write");
   AST_FAULT_GATED: assert property (
      !SUSPEND_FUNCTION_SELECT && fault_q == 2'b00 |=> fault_q == 2'b00)
      else $error("fault set while function select low");
   AST_FAULT_SET: assert property (
      SUSPEND_FUNCTION_SELECT && PORT_SUSPEND_ERR != 2'b00
      |=> (fault_q & $past(PORT_SUSPEND_ERR)) == $past(PORT_SUSPEND_ERR))
      else $error("suspend error did not set fault");
   AST_RESERVED_ZERO: assert property (
      REG_REQ.rd && REG_REQ.addr == `PHYPSR_ADDR_PSTAT1
      |=> REG_RDATA[2:0] == 3'h0 && REG_RVALID)
      else $error("reserved bits not zero");
   AST_SELECT_RESERVED: assert property (
      REG_REQ.rd && REG_REQ.addr == `PHYPSR_ADDR_SELECT |=> !REG_RDATA[4])
      else $error("selector reserved bit not zero");
   AST_OTHER_PAGE_ZERO: assert property (
      REG_REQ.rd && REG_REQ.addr == `PHYPSR_ADDR_PSTAT0 &&
      page_q != `PHYPSR_PAGE_PORT_STATUS |=> REG_RDATA == 8'h00)
      else $error("status page visible on other page");
   AST_WAKE_STOP: assert property (
      LINK_POWER_STATE_INPUT |=> !LINK_WAKE_OUTPUT)
      else $error("wake output active with link powered");
   AST_WAKE_TOGGLE: assert property (
      wake_cond && !wake_q |-> ##[1:16] (wake_q || !wake_cond))
      else $error("wake clock not running");

endmodule

/* File: logic/phypsr_consts.svh */
`ifndef PHYPSR_CONSTS_SVH
`define PHYPSR_CONSTS_SVH

// Register addresses
`define PHYPSR_ADDR_EVENTS      4'h5
`define PHYPSR_ADDR_SELECT      4'h7
`define PHYPSR_ADDR_PSTAT0      4'h8
`define PHYPSR_ADDR_PSTAT1      4'h9

// Event register fields
`define PHYPSR_BIT_WATCHDOG     7
`define PHYPSR_BIT_LOOP         5
`define PHYPSR_BIT_PWR_FAIL     4
`define PHYPSR_BIT_TIMEOUT      3
`define PHYPSR_BIT_PORT_EVENT   2
`define PHYPSR_BIT_ACCEL        1
`define PHYPSR_BIT_MULTI        0

// Selector register fields
`define PHYPSR_PAGE_MSB         7
`define PHYPSR_PAGE_LSB         5
`define PHYPSR_PORT_MSB         3
`define PHYPSR_PORT_LSB         0

// Port status page, first register
`define PHYPSR_PA_MSB           7
`define PHYPSR_PA_LSB           6
`define PHYPSR_PB_MSB           5
`define PHYPSR_PB_LSB           4
`define PHYPSR_BIT_ROLE         3
`define PHYPSR_BIT_ATTACHED     2
`define PHYPSR_BIT_BIAS         1
`define PHYPSR_BIT_PORT_OFF     0

// Port status page, second register
`define PHYPSR_RATE_MSB         7
`define PHYPSR_RATE_LSB         5
`define PHYPSR_BIT_IRQ_EN       4
`define PHYPSR_BIT_FAULT        3

// Page and port codes
`define PHYPSR_PAGE_PORT_STATUS 3'h0
`define PHYPSR_PAGE_VENDOR_ID   3'h1
`define PHYPSR_PAGE_VENDOR_DEP  3'h7
`define PHYPSR_PORT_0           4'h0
`define PHYPSR_PORT_1           4'h1
`define PHYPSR_NUM_PORTS        2

// Reset values
`define PHYPSR_RST_PAGE         3'h0
`define PHYPSR_RST_PORT         4'h0
`define PHYPSR_RST_BYTE         8'h00

// Wake clock timing
`define PHYPSR_CORE_CLK_KHZ     200000
`define PHYPSR_WAKE_CLK_KHZ     6144
`define PHYPSR_WAKE_HALF_CYC \
   (`PHYPSR_CORE_CLK_KHZ / (2 * `PHYPSR_WAKE_CLK_KHZ))

`endif

/* File: logic/phypsr_pkg.sv */
package phypsr_pkg;

   // Live status of one cable port
   typedef struct packed {
      logic [1:0] pair_a_line_state;
      logic [1:0] pair_b_line_state;
      logic       downstream_role;
      logic       link_attached;
      logic       bias_present;
      logic [2:0] peer_top_rate;
   } phypsr_port_stat_t;

   // Register access request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } phypsr_req_t;

endpackage

/* File: testbench/phypsr_lnk.sv */
`timescale 1ns/100ps
module phypsr_lnk
   import phypsr_pkg::*;
(
   // Clock
   input  wire logic       clk,
   // Register access
   output phypsr_req_t     req,
   input  wire logic [7:0] rdata,
   input  wire logic       rvalid
);
   initial req = '0;

   // One access at a time, so the acceleration enable is never changed
   // while another request is still outstanding
   // The testbench selects the vendor dependent page through this model (select write of 8'hff)
   task automatic acc(input logic w, input logic [3:0] a,
                      input logic [7:0] d, output logic [7:0] q,
                      output logic v);
      @(posedge clk);
      #1 req = '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk);
      // Released lines show the inverse, not a stale copy of the value
      #1 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      q = rdata;
      v = rvalid;
   endtask
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/100ps
`include "phypsr_consts.svh"
module testbench
   import phypsr_pkg::*;
;
   localparam logic [3:0] AEV = `PHYPSR_ADDR_EVENTS;
   localparam logic [3:0] ASL = `PHYPSR_ADDR_SELECT;
   localparam logic [3:0] AP0 = `PHYPSR_ADDR_PSTAT0;
   localparam logic [3:0] AP1 = `PHYPSR_ADDR_PSTAT1;
   logic              clk, rst, rvalid, arb_to, loop_f, pwr_f, sel, link_power_state_input;
   logic              accel, multi, wake, v;
   logic [7:0]        rdata, q;
   logic [1:0]        resume, serr, port_off;
   logic [2:0]        page;
   phypsr_req_t       req;
   phypsr_port_stat_t pst [`PHYPSR_NUM_PORTS];
   int                err_total, compares;

   phypsr_lnk phypsr_lnk_inst (.clk(clk), .req(req), .rdata(rdata),
      .rvalid(rvalid));
   phypsr_regs phypsr_regs_inst (.CORE_CLK(clk), .RST(rst), .REG_REQ(req),
      .REG_RDATA(rdata), .REG_RVALID(rvalid), .ARB_TIMEOUT(arb_to),
      .LOOP_FLAG(loop_f), .PWR_FAIL_FLAG(pwr_f),
      .SUSPEND_FUNCTION_SELECT(sel), .LINK_POWER_STATE_INPUT(link_power_state_input),
      .PORT_STAT(pst), .PORT_RESUME(resume), .PORT_SUSPEND_ERR(serr),
      .ARB_ACCEL_EN(accel), .MULTISPEED_EN(multi), .PORT_OFF(port_off),
      .PAGE_SEL(page), .LINK_WAKE_OUTPUT(wake));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      phypsr_lnk_inst.acc(1'b1, a, d, q, v);
   endtask

   // Read data is taken in the cycle that the valid pulse stands
   task automatic rc(input string what, input logic [3:0] a,
                     input logic [7:0] e);
      phypsr_lnk_inst.acc(1'b0, a, 8'h00, q, v);
      check("read valid", {7'h00, v}, 8'h01);
      check(what, q, e);
   endtask

   function automatic logic [7:0] st0(input int p, input logic off);
      return {pst[p].pair_a_line_state, pst[p].pair_b_line_state,
              pst[p].downstream_role, pst[p].link_attached,
              pst[p].bias_present, off};
   endfunction

   task automatic t_reset;
      rc("events", AEV, 8'h00);
      rc("select", ASL, 8'h00);
      check("page out", {5'h00, page}, 8'h00);
      rc("stat0", AP0, st0(0, 1'b0));
      rc("stat1", AP1, {pst[0].peer_top_rate, 5'h00});
      $display("test reset done");
   endtask

   task automatic t_timeout;
      arb_to = 1'b1;
      tick(1);
      arb_to = 1'b0;
      rc("timeout set", AEV, 8'h08);
      wr(AEV, 8'h00);
      rc("timeout kept", AEV, 8'h08);
      wr(AEV, 8'h08);
      rc("timeout clear", AEV, 8'h00);
      $display("test timeout done");
   endtask

   task automatic t_accel;
      wr(AEV, 8'h02);
      check("accel on", {6'h00, accel, multi}, 8'h02);
      wr(AEV, 8'h01);
      check("multi on", {6'h00, accel, multi}, 8'h01);
      rc("ctl read", AEV, 8'h01);
      wr(AEV, 8'h00);
      $display("test accel done");
   endtask

   task automatic t_select;
      wr(ASL, 8'hff);
      rc("sel all", ASL, 8'hef);
      check("page out", {5'h00, page}, 8'h07);
      wr(ASL, 8'h20);
      rc("vendor page", AP0, 8'h00);
      wr(ASL, 8'h02);
      rc("unused port", AP0, 8'h00);
      wr(ASL, 8'h00);
      $display("test select done");
   endtask

   task automatic t_ports;
      for (int i = 0; i < 4; i++)
      begin
         pst[0].pair_a_line_state = i[1:0];
         pst[0].pair_b_line_state = ~i[1:0];
         pst[0].peer_top_rate = 3'(i % 3);
         pst[0].downstream_role = i[0];
         pst[0].bias_present = i[1];
         rc("line", AP0, st0(0, 1'b0));
         rc("rate", AP1, {pst[0].peer_top_rate, 5'h00});
      end
      wr(ASL, 8'h01);
      wr(AP0, 8'h01);
      check("port off", {6'h00, port_off}, 8'h02);
      rc("port1", AP0, st0(1, 1'b1));
      wr(ASL, 8'h00);
      rc("port0", AP0, st0(0, 1'b0));
      wr(ASL, 8'h01);
      wr(AP0, 8'h00);
      wr(ASL, 8'h00);
      $display("test ports done");
   endtask

   task automatic t_event;
      logic [7:0] r;
      r = {pst[0].peer_top_rate, 5'h00};
      sel = 1'b1;
      wr(AP1, 8'h10);
      pst[0].link_attached = 1'b1;
      rc("chg event", AEV, 8'h04);
      wr(AEV, 8'h04);
      rc("event clr", AEV, 8'h00);
      pst[1].bias_present = 1'b1;
      rc("port1 off", AEV, 8'h00);
      sel = 1'b0;
      wr(AEV, 8'h80);
      pst[0].link_attached = 1'b0;
      resume = 2'b10;
      serr = 2'b01;
      tick(1);
      resume = 2'b00;
      serr = 2'b00;
      rc("sel low", AEV, 8'h80);
      rc("fault low", AP1, r | 8'h10);
      sel = 1'b1;
      tick(2);
      resume = 2'b10;
      tick(1);
      resume = 2'b00;
      rc("resume evt", AEV, 8'h84);
      wr(AEV, 8'h84);
      serr = 2'b01;
      tick(1);
      serr = 2'b00;
      rc("fault set", AP1, r | 8'h18);
      rc("fault evt", AEV, 8'h84);
      wr(AP1, 8'h10);
      rc("fault kept", AP1, r | 8'h18);
      wr(AP1, 8'h18);
      rc("fault clr", AP1, r | 8'h10);
      wr(AEV, 8'h04);
      rc("all clear", AEV, 8'h00);
      $display("test event done");
   endtask

   task automatic t_wake;
      int n;
      link_power_state_input = 1'b0;
      pst[0].link_attached = 1'b1;
      for (n = 0; n < 40 && wake !== 1'b1; n++)
         tick(1);
      check("wake rise", {7'h00, wake}, 8'h01);
      for (n = 0; n < 40 && wake !== 1'b0; n++)
         tick(1);
      check("wake fall", {7'h00, wake}, 8'h00);
      check("wake half", 8'(n), 8'(`PHYPSR_WAKE_HALF_CYC));
      link_power_state_input = 1'b1;
      tick(3);
      check("wake stop", {7'h00, wake}, 8'h00);
      wr(AEV, 8'h04);
      {loop_f, pwr_f, link_power_state_input} = 3'b110;
      rc("loop pwr", AEV, 8'h30);
      tick(20);
      check("wake masked", {7'h00, wake}, 8'h00);
      wr(AEV, 8'h80);
      for (n = 0; n < 40 && wake !== 1'b1; n++)
         tick(1);
      check("wake loop", {7'h00, wake}, 8'h01);
      {loop_f, pwr_f, link_power_state_input} = 3'b001;
      wr(AEV, 8'h00);
      $display("test wake done");
   endtask

   task automatic close_out;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      #50000;
      err_total++;
      $display("watchdog expired");
      close_out;
   end

   initial
   begin
      rst = 1'b1;
      {arb_to, loop_f, pwr_f, sel} = 4'h0;
      link_power_state_input = 1'b1;
      resume = 2'b00;
      serr = 2'b00;
      pst[0] = '{2'b10, 2'b01, 1'b1, 1'b0, 1'b1, 3'h2};
      pst[1] = '{2'b11, 2'b00, 1'b0, 1'b1, 1'b0, 3'h1};
      err_total = 0;
      compares = 0;
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      t_reset;
      t_timeout;
      t_accel;
      t_select;
      t_ports;
      t_event;
      t_wake;
      close_out;
   end
endmodule
